// file: src/serial_state_notifier.sv
// Serial line state notification framer, device side
// What this block does
// - Ten bytes: header fields then two status bytes
// - Byte zero is request type A1
// - Byte one is notification code 20
// - Value zero, index zero for interface zero
// - Length field equals two
// - Standard layout drives bits fifteen to seven zero
// - Bit six flags receive overrun
// - Bit five flags parity error
// - Bit four flags framing error
// - Bit three follows ring indicator
// - Bit two follows break detector
// - Bit one follows data set ready
// - Bit zero follows carrier detect
// - Vendor mapping adds aux pins to high byte
// - Aux pins at bits 14,13,12,11,9,8; others zero
// - Each aux bit gated by its enable
// - Unmasked input aux change queues notification
`timescale 1ns/100ps
`include "ssn_defs.svh"
module serial_state_notifier (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic overrun_evt,
    input wire logic parity_evt,
    input wire logic framing_evt,
    input wire logic brk_det,
    input wire logic ring_pin,
    input wire logic dsr_pin,
    input wire logic dcd_pin,
    input wire logic aux_pin_zero,
    input wire logic aux_pin_one,
    input wire logic aux_pin_two,
    input wire logic aux_pin_three,
    input wire logic aux_pin_four,
    input wire logic aux_pin_five,
    input wire logic [`AUX_W-1:0] aux_dir,
    input wire logic [`AUX_W-1:0] aux_int_mask,
    input wire logic [`CFG_W-1:0] notify_cfg,
    input wire logic vendor_map_en,
    input wire logic in_token,
    output logic [7:0] pkt_byte,
    output logic pkt_valid,
    output logic pkt_last,
    output logic in_nak,
    output logic notify_pending
);
    ssn_pkg::state_t st;
    ssn_pkg::state_t next_st;
    logic [`WORD_W-1:0] live;
    logic [`LVL_W-1:0] lvl;
    logic [`AUX_W-1:0] aux;
    logic [`ERR_W-1:0] evt;
    logic trigger;
    logic accept;

    ssn_frame_if frame ();

    ssn_byte_pick pick (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .port(frame.picker)
    );

    assign frame.idx = st.idx;
    assign frame.word = st.snap;

    always_comb begin
        next_st = st;
        evt = '0;
        evt[`ERR_OVR] = overrun_evt;
        evt[`ERR_PAR] = parity_evt;
        evt[`ERR_FRM] = framing_evt;
        aux = st.pin_s2[`PIN_W-1:`PIN_AUX];
        lvl = {st.pin_s2[`PIN_DCD], st.pin_s2[`PIN_DSR], brk_det, st.pin_s2[`PIN_RING]};

        // Live status word; unlisted bits stay zero
        live = '0;
        live[`D_OVR] = st.err[`ERR_OVR];
        live[`D_PAR] = st.err[`ERR_PAR];
        live[`D_FRM] = st.err[`ERR_FRM];
        live[`D_RING] = st.pin_s2[`PIN_RING];
        live[`D_BRK] = brk_det;
        live[`D_DSR] = st.pin_s2[`PIN_DSR];
        live[`D_DCD] = st.pin_s2[`PIN_DCD];
        if (vendor_map_en) begin
            live[`D_AUX5] = aux[`AUX5] & notify_cfg[`EN_AUX5];
            live[`D_AUX4] = aux[`AUX4] & notify_cfg[`EN_AUX4];
            live[`D_AUX3] = aux[`AUX3] & notify_cfg[`EN_AUX3];
            live[`D_AUX0] = aux[`AUX0] & notify_cfg[`EN_AUX0];
            live[`D_AUX2] = aux[`AUX2] & notify_cfg[`EN_AUX2];
            live[`D_AUX1] = aux[`AUX1] & notify_cfg[`EN_AUX1];
        end

        // Any line level change, error event or unmasked input aux change queues a packet
        trigger = (|(lvl ^ st.prev_lvl)) | (|evt)
            | (|((aux ^ st.prev_aux) & ~aux_dir & ~aux_int_mask));
        accept = in_token & (st.phase == ssn_pkg::IDLE) & st.pending;

        // Two-stage synchronisers for pin inputs
        next_st.pin_s1 = {aux_pin_five, aux_pin_four, aux_pin_three, aux_pin_two, aux_pin_one,
            aux_pin_zero, dcd_pin, dsr_pin, ring_pin};
        next_st.pin_s2 = st.pin_s1;
        next_st.prev_lvl = lvl;
        next_st.prev_aux = aux;

        // Set wins over the clear taken with the packet
        next_st.err = evt | (st.err & ~{`ERR_W{accept}});
        next_st.pending = trigger | (st.pending & ~accept);
        next_st.nak = in_token & ~accept;

        next_st.v1 = (st.phase == ssn_pkg::SEND);
        next_st.l1 = (st.phase == ssn_pkg::SEND) && (st.idx == `IDX_LAST);
        next_st.valid = st.v1;
        next_st.last = st.l1;
        next_st.byte_out = frame.data;

        unique case (st.phase)
            ssn_pkg::IDLE: begin
                if (accept) begin
                    next_st.snap = live;
                    next_st.idx = '0;
                    next_st.phase = ssn_pkg::SEND;
                end
            end
            ssn_pkg::SEND: begin
                next_st.idx = `IDX_W'(st.idx + 1'b1);
                if (st.idx == `IDX_LAST) begin
                    next_st.phase = ssn_pkg::FLUSH;
                end
            end
            ssn_pkg::FLUSH: begin
                if (!st.v1) begin
                    next_st.phase = ssn_pkg::IDLE;
                end
            end
            default: begin
                next_st.phase = ssn_pkg::IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= `RESET_STATE;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign pkt_byte = st.byte_out;
    assign pkt_valid = st.valid;
    assign pkt_last = st.last;
    assign in_nak = st.nak;
    assign notify_pending = st.pending;

    default clocking cb @(posedge clk iff clk_en);
    endclocking
    default disable iff (!rst_n);

    sequence s_hdr_start;
        pkt_valid && pkt_byte == `REQ_TYPE_VAL ##1 pkt_valid && pkt_byte == `NOTIF_VAL;
    endsequence

    sequence s_hdr_zero;
        pkt_byte == `FILL_BYTE ##1 pkt_byte == `FILL_BYTE ##1 pkt_byte == `FILL_BYTE
            ##1 pkt_byte == `FILL_BYTE;
    endsequence

    a_pkt_ten_bytes: assert property ($rose(pkt_valid) |-> ##9 (pkt_valid && pkt_last) ##1 !pkt_valid)
        else $error("packet is not ten bytes");

    a_hdr_codes: assert property ($rose(pkt_valid) |-> s_hdr_start)
        else $error("header start bytes wrong");

    a_value_index: assert property ($rose(pkt_valid) |-> ##2 s_hdr_zero)
        else $error("value or index not zero");

    a_length_two: assert property ($rose(pkt_valid) |-> ##6 pkt_byte == `LENGTH_VAL >> 0 ##1 pkt_byte == `FILL_BYTE)
        else $error("length field not two");

    a_std_upper: assert property (accept && !vendor_map_en |=> st.snap[`WORD_W-1:`D_STD_TOP] == '0)
        else $error("standard word has upper bits set");

    a_rsv_bits: assert property (!st.snap[`D_RSV15] && !st.snap[`D_RSV10] && !st.snap[`D_STD_TOP])
        else $error("reserved status bit set");

    a_err_set_wins: assert property (overrun_evt |=> st.err[`ERR_OVR] && st.pending)
        else $error("overrun event lost");

    a_token_answer: assert property (accept |-> ##3 $rose(pkt_valid))
        else $error("accepted token did not start packet");

    a_nak_idle: assert property (in_token && !st.pending && st.phase == ssn_pkg::IDLE
        |=> in_nak && !pkt_valid)
        else $error("idle token not refused");

    a_data_low: assert property (accept |-> ##11 pkt_byte == $past(live[7:0], 11))
        else $error("status low byte wrong");

    a_masked_quiet: assert property (!st.pending && !trigger |=> !st.pending)
        else $error("pending without cause");

    property p_aux_bit(int d, int a, int e);
        accept && vendor_map_en |=> st.snap[d] == $past(aux[a] & notify_cfg[e]);
    endproperty

    sequence s_send_run;
        st.phase == ssn_pkg::SEND [*8] ##1 st.phase == ssn_pkg::SEND ##1 st.phase == ssn_pkg::SEND;
    endsequence

    a_nak_token: assert property (!in_token |=> !in_nak)
        else $error("refusal without token");

    a_busy_refuse: assert property (in_token && st.phase != ssn_pkg::IDLE |=> in_nak)
        else $error("token during packet not refused");

    a_accept_quiet: assert property (accept |=> !in_nak)
        else $error("accepted token refused");

    a_pending_clear: assert property (accept && !trigger |=> !notify_pending)
        else $error("pending kept after accept");

    a_trigger_queue: assert property (trigger |=> notify_pending)
        else $error("change not queued");

    a_last_single: assert property (pkt_last |=> !pkt_last)
        else $error("last flag longer than one byte");

    a_last_valid: assert property (pkt_last |-> pkt_valid)
        else $error("last flag without valid byte");

    a_valid_run: assert property ($rose(pkt_valid) |-> pkt_valid [*8] ##1 pkt_valid
        ##1 pkt_valid ##1 !pkt_valid)
        else $error("valid run not ten bytes");

    a_send_phase: assert property (accept |=> s_send_run ##1 st.phase == ssn_pkg::FLUSH)
        else $error("send phase length wrong");

    a_quiet_start: assert property (accept |=> !pkt_valid ##1 !pkt_valid ##1 pkt_valid)
        else $error("packet start timing wrong");

    a_data_high: assert property (accept |-> ##12 pkt_byte == $past(live[15:8], 12))
        else $error("status high byte wrong");

    a_snap_ovr: assert property (accept |=> st.snap[`D_OVR] == $past(st.err[`ERR_OVR]))
        else $error("overrun bit not captured");

    a_snap_par: assert property (accept |=> st.snap[`D_PAR] == $past(st.err[`ERR_PAR]))
        else $error("parity bit not captured");

    a_snap_frm: assert property (accept |=> st.snap[`D_FRM] == $past(st.err[`ERR_FRM]))
        else $error("framing bit not captured");

    a_snap_ring: assert property (accept |=> st.snap[`D_RING] == $past(st.pin_s2[`PIN_RING]))
        else $error("ring bit not captured");

    a_snap_brk: assert property (accept |=> st.snap[`D_BRK] == $past(brk_det))
        else $error("break bit not captured");

    a_snap_dsr: assert property (accept |=> st.snap[`D_DSR] == $past(st.pin_s2[`PIN_DSR]))
        else $error("data set ready bit not captured");

    a_snap_dcd: assert property (accept |=> st.snap[`D_DCD] == $past(st.pin_s2[`PIN_DCD]))
        else $error("carrier detect bit not captured");

    a_snap_aux5: assert property (p_aux_bit(`D_AUX5, `AUX5, `EN_AUX5))
        else $error("aux pin five bit wrong");

    a_snap_aux4: assert property (p_aux_bit(`D_AUX4, `AUX4, `EN_AUX4))
        else $error("aux pin four bit wrong");

    a_snap_aux3: assert property (p_aux_bit(`D_AUX3, `AUX3, `EN_AUX3))
        else $error("aux pin three bit wrong");

    a_snap_aux0: assert property (p_aux_bit(`D_AUX0, `AUX0, `EN_AUX0))
        else $error("aux pin zero bit wrong");

    a_snap_aux2: assert property (p_aux_bit(`D_AUX2, `AUX2, `EN_AUX2))
        else $error("aux pin two bit wrong");

    a_snap_aux1: assert property (p_aux_bit(`D_AUX1, `AUX1, `EN_AUX1))
        else $error("aux pin one bit wrong");

    a_ovr_sticky: assert property (st.err[`ERR_OVR] && !accept |=> st.err[`ERR_OVR])
        else $error("overrun flag lost before report");

    a_par_sticky: assert property (st.err[`ERR_PAR] && !accept |=> st.err[`ERR_PAR])
        else $error("parity flag lost before report");

    a_frm_sticky: assert property (st.err[`ERR_FRM] && !accept |=> st.err[`ERR_FRM])
        else $error("framing flag lost before report");

    a_par_clear: assert property (accept && !parity_evt |=> !st.err[`ERR_PAR])
        else $error("parity flag kept after report");

    a_aux_queue: assert property (|((aux ^ st.prev_aux) & ~aux_dir & ~aux_int_mask) |=> notify_pending)
        else $error("aux change not queued");

    a_brk_queue: assert property ($changed(brk_det) && $past(rst_n) |=> notify_pending)
        else $error("break change not queued");

    a_par_queue: assert property (parity_evt |=> notify_pending && st.err[`ERR_PAR])
        else $error("parity event lost");

    a_frm_queue: assert property (framing_evt |=> notify_pending && st.err[`ERR_FRM])
        else $error("framing event lost");
endmodule : serial_state_notifier

// file: src/ssn_defs.svh
// Constants for the serial line state notification framer
`ifndef SSN_DEFS_SVH
`define SSN_DEFS_SVH
// Packet layout, byte offsets
`define OFS_REQ_TYPE 4'h0
`define OFS_NOTIF 4'h1
`define OFS_VALUE_LO 4'h2
`define OFS_VALUE_HI 4'h3
`define OFS_INDEX_LO 4'h4
`define OFS_INDEX_HI 4'h5
`define OFS_LENGTH_LO 4'h6
`define OFS_LENGTH_HI 4'h7
`define OFS_DATA_LO 4'h8
`define OFS_DATA_HI 4'h9
`define IDX_LAST 4'h9
`define IDX_W 4
// Header field values
`define REQ_TYPE_VAL 8'hA1
`define NOTIF_VAL 8'h20
`define VALUE_VAL 16'h0000
`define INDEX_VAL 16'h0000
`define LENGTH_VAL 16'h0002
`define FILL_BYTE 8'h00
// Status word bit positions
`define WORD_W 16
`define D_DCD 0
`define D_DSR 1
`define D_BRK 2
`define D_RING 3
`define D_FRM 4
`define D_PAR 5
`define D_OVR 6
`define D_STD_TOP 7
`define D_AUX1 8
`define D_AUX2 9
`define D_RSV10 10
`define D_AUX0 11
`define D_AUX3 12
`define D_AUX4 13
`define D_AUX5 14
`define D_RSV15 15
// Per-pin enable bits of the notify configuration
`define EN_AUX1 0
`define EN_AUX2 1
`define EN_AUX0 3
`define EN_AUX3 4
`define EN_AUX4 5
`define EN_AUX5 6
`define CFG_W 8
// Synchronised pin vector layout
`define PIN_RING 0
`define PIN_DSR 1
`define PIN_DCD 2
`define PIN_AUX 3
`define PIN_W 9
`define AUX_W 6
`define AUX0 0
`define AUX1 1
`define AUX2 2
`define AUX3 3
`define AUX4 4
`define AUX5 5
// Sticky error vector layout
`define ERR_FRM 0
`define ERR_PAR 1
`define ERR_OVR 2
`define ERR_W 3
`define LVL_W 4
`define RESET_STATE '0
`endif

// file: src/ssn_pkg.sv
// Types for the serial line state notification framer
`include "ssn_defs.svh"
package ssn_pkg;
    typedef enum logic [1:0] {
        IDLE = 2'h0,
        SEND = 2'h1,
        FLUSH = 2'h3
    } phase_t;

    typedef struct packed {
        phase_t phase;
        logic [`IDX_W-1:0] idx;
        logic [`WORD_W-1:0] snap;
        logic [`ERR_W-1:0] err;
        logic [`PIN_W-1:0] pin_s1;
        logic [`PIN_W-1:0] pin_s2;
        logic [`LVL_W-1:0] prev_lvl;
        logic [`AUX_W-1:0] prev_aux;
        logic pending;
        logic v1;
        logic l1;
        logic valid;
        logic last;
        logic [7:0] byte_out;
        logic nak;
    } state_t;
endpackage : ssn_pkg

// file: src/ssn_frame_if.sv
// Link between the framer and its byte picker
`timescale 1ns/100ps
`include "ssn_defs.svh"
interface ssn_frame_if;
    logic [`IDX_W-1:0] idx;
    logic [`WORD_W-1:0] word;
    logic [7:0] data;
    modport picker (input idx, input word, output data);
    modport framer (output idx, output word, input data);
endinterface : ssn_frame_if

// file: src/ssn_byte_pick.sv
// Registered byte picker for the ten-byte notification
`timescale 1ns/100ps
`include "ssn_defs.svh"
module ssn_byte_pick (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    ssn_frame_if.picker port
);
    // Header fields go out low byte first
    function automatic logic [7:0] pick(input logic [`IDX_W-1:0] i, input logic [`WORD_W-1:0] w);
        logic [7:0] b;
        b = `FILL_BYTE;
        unique case (i)
            `OFS_REQ_TYPE: b = `REQ_TYPE_VAL;
            `OFS_NOTIF: b = `NOTIF_VAL;
            `OFS_VALUE_LO: b = 8'(`VALUE_VAL >> 0);
            `OFS_VALUE_HI: b = 8'(`VALUE_VAL >> 8);
            `OFS_INDEX_LO: b = 8'(`INDEX_VAL >> 0);
            `OFS_INDEX_HI: b = 8'(`INDEX_VAL >> 8);
            `OFS_LENGTH_LO: b = 8'(`LENGTH_VAL >> 0);
            `OFS_LENGTH_HI: b = 8'(`LENGTH_VAL >> 8);
            `OFS_DATA_LO: b = w[7:0];
            `OFS_DATA_HI: b = w[15:8];
            default: b = `FILL_BYTE;
        endcase
        return b;
    endfunction : pick

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            port.data <= `FILL_BYTE;
        end else if (clk_en) begin
            port.data <= pick(port.idx, port.word);
        end
    end

    a_pick_req: assert property (@(posedge clk iff clk_en) disable iff (!rst_n)
        port.idx == `OFS_REQ_TYPE |=> port.data == `REQ_TYPE_VAL)
        else $error("request type byte wrong");
endmodule : ssn_byte_pick

// file: verification/usb_host_model.sv
// Host side model: polls the interrupt endpoint and gathers one packet
`timescale 1ns/100ps
module usb_host_model (
    input wire logic clk,
    output logic in_token,
    input wire logic [7:0] pkt_byte,
    input wire logic pkt_valid,
    input wire logic pkt_last,
    input wire logic in_nak
);
    logic [7:0] rx [10];

    initial in_token = 1'h0;

    // One token per poll, then every byte is taken until last or a refusal
    task automatic poll(output logic nak, output int got, output logic tmo);
        int n;
        nak = 1'h0;
        got = 0;
        tmo = 1'h1;
        @(posedge clk) #1 in_token = 1'h1;
        @(posedge clk) #1 in_token = 1'h0;
        for (n = 0; n < 20; n++) begin
            if (in_nak === 1'h1) begin
                nak = 1'h1;
                tmo = 1'h0;
                break;
            end
            if (pkt_valid === 1'h1) begin
                if (got < 10) rx[got] = pkt_byte;
                got++;
                if (pkt_last === 1'h1) begin
                    tmo = 1'h0;
                    break;
                end
            end
            @(posedge clk) #1;
        end
    endtask : poll
endmodule : usb_host_model

// file: verification/serial_state_notifier_tb.sv
// Self-checking bench for the serial line state notifier
`timescale 1ns/100ps
module serial_state_notifier_tb;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [2:0] err = 3'h0;
    logic [3:0] line = 4'h0;
    logic [5:0] aux = 6'h00;
    logic [5:0] aux_dir = 6'h00;
    logic [5:0] mask = 6'h00;
    logic [7:0] cfg = 8'h00;
    logic vmap = 1'h0;
    logic run = 1'h1;
    logic in_token, pkt_valid, pkt_last, in_nak, pending;
    logic [7:0] pkt_byte;
    logic [7:0] hdr [8] = '{8'hA1, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
    int errors = 0;
    int num_checks = 0;

    always #50 clk = ~clk;

    serial_state_notifier dut (.clk(clk), .rst_n(rst_n), .clk_en(run), .overrun_evt(err[2]), .parity_evt(err[1]),
        .framing_evt(err[0]), .brk_det(line[2]), .ring_pin(line[3]), .dsr_pin(line[1]), .dcd_pin(line[0]),
        .aux_pin_zero(aux[0]), .aux_pin_one(aux[1]), .aux_pin_two(aux[2]), .aux_pin_three(aux[3]),
        .aux_pin_four(aux[4]), .aux_pin_five(aux[5]), .aux_dir(aux_dir), .aux_int_mask(mask),
        .notify_cfg(cfg), .vendor_map_en(vmap), .in_token(in_token), .pkt_byte(pkt_byte),
        .pkt_valid(pkt_valid), .pkt_last(pkt_last), .in_nak(in_nak), .notify_pending(pending));

    usb_host_model host (.clk(clk), .in_token(in_token), .pkt_byte(pkt_byte), .pkt_valid(pkt_valid),
        .pkt_last(pkt_last), .in_nak(in_nak));

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk) #1;
    endtask : tick

    task automatic pulse(input logic [2:0] e);
        @(posedge clk) #1 err = e;
        @(posedge clk) #1 err = 3'h0;
        tick(1);
        check({7'h00, pending}, 8'h01);
    endtask : pulse

    task automatic expect_pkt(input logic [7:0] lo, input logic [7:0] hi);
        logic nak;
        int got;
        logic tmo;
        host.poll(nak, got, tmo);
        if (tmo) begin
            errors++;
            stop_test();
        end else begin
            check({7'h00, nak}, 8'h00);
            check(8'(got), 8'h0A);
            for (int i = 0; i < 8; i++) check(host.rx[i], hdr[i]);
            check(host.rx[8], lo);
            check(host.rx[9], hi);
        end
    endtask : expect_pkt

    task automatic expect_nak();
        logic nak;
        int got;
        logic tmo;
        host.poll(nak, got, tmo);
        if (tmo) begin
            errors++;
            stop_test();
        end else begin
            check({7'h00, nak}, 8'h01);
        end
    endtask : expect_nak

    // High status byte from pin levels and per-pin enables
    function automatic logic [7:0] high_byte(input logic [5:0] a, input logic [7:0] c);
        return {1'h0, a[5] & c[6], a[4] & c[5], a[3] & c[4], a[0] & c[3], 1'h0, a[2] & c[1], a[1] & c[0]};
    endfunction : high_byte

    initial begin
        repeat (4) @(posedge clk);
        #1 rst_n = 1'h1;
        check({7'h00, pending}, 8'h00);
        expect_nak();
        $display("test idle_refusal done");
        for (int i = 0; i < 3; i++) begin
            pulse(3'(1 << i));
            expect_pkt(8'h10 << i, 8'h00);
        end
        expect_nak();
        $display("test error_bits done");
        for (int i = 0; i < 4; i++) begin
            line[i] = 1'h1;
            tick(5);
            expect_pkt({4'h0, line}, 8'h00);
        end
        $display("test line_bits done");
        vmap = 1'h1;
        cfg = 8'h7B;
        for (int i = 0; i < 6; i++) begin
            aux[i] = 1'h1;
            tick(5);
            expect_pkt(8'h0F, high_byte(aux, cfg));
        end
        for (int k = 0; k < 8; k++) begin
            cfg = 8'(1 << k);
            pulse(3'h2);
            expect_pkt(8'h2F, high_byte(aux, cfg));
        end
        vmap = 1'h0;
        cfg = 8'h7B;
        pulse(3'h2);
        expect_pkt(8'h2F, 8'h00);
        $display("test vendor_map done");
        mask = 6'h01;
        aux[0] = 1'h0;
        tick(5);
        expect_nak();
        aux_dir = 6'h02;
        aux[1] = 1'h0;
        tick(5);
        expect_nak();
        mask = 6'h00;
        aux_dir = 6'h00;
        aux[2] = 1'h0;
        tick(5);
        expect_pkt(8'h0F, 8'h00);
        $display("test aux_trigger done");
        run = 1'h0;
        err = 3'h2;
        tick(3);
        check({7'h00, pending}, 8'h00);
        err = 3'h0;
        run = 1'h1;
        tick(1);
        check({7'h00, pending}, 8'h00);
        expect_nak();
        $display("test clock_enable done");
        stop_test();
    end
endmodule : serial_state_notifier_tb
